// >>> core/sss_pkg.sv
/*
  Shared constants and types of the safe stop sequencer: register map,
  field positions, reset values, monitoring tick timing and the state set.
  Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
package sss_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 4;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int DELAY_W = 16;
  localparam int SYNC_N = 3;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_DELAY = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_TIMER = 8'h10;
  localparam logic [7:0] OFF_FLOG = 8'h14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CUT = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RUN = 2;
  localparam int CFG_EXT = 0;
  localparam int CFG_BRAKE = 1;
  localparam int CFG_FDI_STOP = 2;
  localparam int FLOG_SEEN = 0;
  localparam int PIN_FDI = 0;
  localparam int PIN_SPD = 1;
  localparam int PIN_FLT = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic run_command;
    logic controlled_stop;
    logic torque_cut;
  } sss_ctrl_t;

  typedef struct packed {
    logic fdi_stop_select;
    logic brake_configured;
    logic external_stop_select;
  } sss_cfg_t;

  typedef struct packed {
    logic quick_stop_ramp;
    logic brake_close;
    logic running;
    logic ready;
    logic safety_fault;
    logic controlled_stop_active;
    logic torque_cut_active;
  } sss_status_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_READY,
    ST_RUN,
    ST_STOP,
    ST_CUT,
    ST_RELEASE
  } sss_state_t;

endpackage

// >>> core/sss_top.sv
/*
  Safe stop sequencer top: APB register slave, pin synchronisers,
  monitoring tick, stop/cut state machine and registered drive outputs.
  Assumes a 100 MHz pclk, an APB3 master and a safety controller that
  writes its telegram control bits into the control register.
*/
// Contract
// - telegram bit or fail-safe input selects cut
// - cut active shown in status
// - select then deselect cut acknowledges fault
// - cut closes brake when brake configured
// - release: brake cancel first, then fault/cut
// - config bit picks external or ramp stop
// - ramp stop: ramp and timer start together
// - timer expiry forces cut regardless of speed
// - ramp deceleration itself is not monitored
// - external stop: timer runs, no ramp
// - telegram bit or fail-safe input selects stop
// - stop active shown, kept during cut
// - deselection never aborts a running stop
// - pulses inhibited while cut active
// - restart only on run command rising edge
// - state machine evaluated once per 4 ms tick
module sss_top #(
  parameter int TICK_CYCLES = sss_pkg::TICK_CYCLES,
  parameter int DELAY_W = sss_pkg::DELAY_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sss_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic failsafe_input_n,
  input wire logic speed_below_shutdown,
  input wire logic fault_cause,
  output logic pulse_enable,
  output logic brake_close,
  output logic quick_stop_ramp,
  output logic torque_cut_active,
  output logic controlled_stop_active,
  output logic ready_to_switch_on
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 2 || DELAY_W < 1 || DELAY_W > 32) begin : g_bad_param
    $error("sss_top: unsupported TICK_CYCLES or DELAY_W");
  end

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  function automatic logic hit(input logic [sss_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire logic setup_ph = psel & ~penable;
  wire logic acc_ph = psel & penable & pready;
  wire logic wr_acc = acc_ph & pwrite;
  wire logic hit_ctrl = hit(paddr, sss_pkg::OFF_CTRL);
  wire logic hit_cfg = hit(paddr, sss_pkg::OFF_CFG);
  wire logic hit_delay = hit(paddr, sss_pkg::OFF_DELAY);
  wire logic hit_status = hit(paddr, sss_pkg::OFF_STATUS);
  wire logic hit_timer = hit(paddr, sss_pkg::OFF_TIMER);
  wire logic hit_flog = hit(paddr, sss_pkg::OFF_FLOG);
  wire logic mapped = hit_ctrl | hit_cfg | hit_delay | hit_status | hit_timer | hit_flog;
  wire logic ro_hit = hit_status | hit_timer;

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  sss_pkg::sss_ctrl_t ctrl_r;
  sss_pkg::sss_cfg_t cfg_r;
  logic [DELAY_W-1:0] delay_r;
  logic flog_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  logic [sss_pkg::SYNC_N-1:0] s1_r, s2_r, s3_r, filt_r;
  sss_pkg::sss_state_t state_r, state_nxt;
  logic [DELAY_W-1:0] timer_r, timer_nxt;
  logic fault_r, armed_r, cs_latch_r, run_prev_r;
  logic cut_act_r, cs_act_r, pulse_r, brake_r, ramp_r, ready_r, run_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  // control, config and delay writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= sss_pkg::CTRL_RST;
      cfg_r <= sss_pkg::CFG_RST;
      delay_r <= DELAY_W'(sss_pkg::DELAY_RST);
    end else begin
      if (wr_acc && hit_ctrl) ctrl_r <= pwdata[2:0];
      if (wr_acc && hit_cfg) cfg_r <= pwdata[2:0];
      if (wr_acc && hit_delay) delay_r <= pwdata[DELAY_W-1:0];
    end
  end

  // fault log: sticky, cleared only by write-one, a new fault wins
  wire logic flog_clr = wr_acc & hit_flog & pwdata[sss_pkg::FLOG_SEEN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flog_r <= 1'b0;
    else flog_r <= filt_r[sss_pkg::PIN_FLT] | (flog_r & ~flog_clr);
  end

  // -----------------------------------------------------------------
  // read path and bus answer
  // -----------------------------------------------------------------
  wire sss_pkg::sss_status_t status_w = '{quick_stop_ramp: ramp_r, brake_close: brake_r,
    running: run_r, ready: ready_r, safety_fault: fault_r,
    controlled_stop_active: cs_act_r, torque_cut_active: cut_act_r};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl_r} :
    hit_cfg ? {29'h0, cfg_r} :
    hit_delay ? 32'(delay_r) :
    hit_status ? {25'h0, status_w} :
    hit_timer ? 32'(timer_r) :
    hit_flog ? {31'h0, flog_r} : 32'h0;

  // one wait-free access: answer captured in setup, pready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & (~mapped | (pwrite & ro_hit));
      if (setup_ph) prdata_r <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // -----------------------------------------------------------------
  // pin synchronisers, change accepted when stages two and three agree
  // -----------------------------------------------------------------
  wire logic [sss_pkg::SYNC_N-1:0] pins_w = {fault_cause, speed_below_shutdown, failsafe_input_n};
  wire logic [sss_pkg::SYNC_N-1:0] filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      filt_r <= 3'h0;
    end else begin
      s1_r <= pins_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // -----------------------------------------------------------------
  // monitoring tick
  // -----------------------------------------------------------------
  wire logic tick_wrap = (tick_cnt_r == TW'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TW'(1);
      tick_r <= tick_wrap;
    end
  end

  // -----------------------------------------------------------------
  // selections
  // -----------------------------------------------------------------
  wire logic fdi_sel = ~filt_r[sss_pkg::PIN_FDI];
  wire logic spd_low = filt_r[sss_pkg::PIN_SPD];
  wire logic flt_now = filt_r[sss_pkg::PIN_FLT];
  wire logic sel_cut = ctrl_r.torque_cut | (fdi_sel & ~cfg_r.fdi_stop_select);
  wire logic stop_req = ctrl_r.controlled_stop | (fdi_sel & cfg_r.fdi_stop_select);
  wire logic force_cut = sel_cut | fault_r;
  wire logic delay_zero = (delay_r == '0);
  wire logic run_edge = ctrl_r.run_command & ~run_prev_r;
  wire logic expire = (timer_r <= DELAY_W'(1));
  // leaving cut needs all selections gone, cause gone, fault acknowledged
  wire logic cut_exit = ~sel_cut & ~stop_req & ~flt_now & (~fault_r | armed_r);

  // -----------------------------------------------------------------
  // state machine, evaluated on the tick
  // -----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    unique case (state_r)
      sss_pkg::ST_READY, sss_pkg::ST_RUN: begin
        if (force_cut || (stop_req && delay_zero)) begin
          state_nxt = sss_pkg::ST_CUT;
        end else if (stop_req) begin
          state_nxt = sss_pkg::ST_STOP;
          timer_nxt = delay_r;
        end else if (state_r == sss_pkg::ST_READY && run_edge) begin
          state_nxt = sss_pkg::ST_RUN;
        end else if (state_r == sss_pkg::ST_RUN && !ctrl_r.run_command) begin
          state_nxt = sss_pkg::ST_READY;
        end
      end
      sss_pkg::ST_STOP: begin
        // deselection is ignored here; only expiry, speed or cut end it
        timer_nxt = expire ? '0 : timer_r - DELAY_W'(1);
        if (force_cut || expire || spd_low) begin
          state_nxt = sss_pkg::ST_CUT;
        end
      end
      sss_pkg::ST_CUT: begin
        if (cut_exit) state_nxt = sss_pkg::ST_RELEASE;
      end
      sss_pkg::ST_RELEASE: begin
        state_nxt = (sel_cut || stop_req || flt_now) ? sss_pkg::ST_CUT : sss_pkg::ST_READY;
      end
    endcase
  end

  wire logic fault_clr = tick_r & (state_r == sss_pkg::ST_RELEASE) & (state_nxt == sss_pkg::ST_READY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sss_pkg::ST_READY;
      timer_r <= '0;
      run_prev_r <= 1'b0;
    end else if (tick_r) begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      run_prev_r <= ctrl_r.run_command;
    end
  end

  // fault latch, ack arm and stop-active latch; a new fault wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      armed_r <= 1'b0;
      cs_latch_r <= 1'b0;
    end else begin
      fault_r <= flt_now | (fault_r & ~fault_clr);
      if (tick_r && state_nxt == sss_pkg::ST_READY) armed_r <= 1'b0;
      else if (tick_r && state_r == sss_pkg::ST_CUT && sel_cut) armed_r <= 1'b1;
      if (tick_r && state_nxt == sss_pkg::ST_STOP) cs_latch_r <= 1'b1;
      else if (tick_r && state_nxt == sss_pkg::ST_READY) cs_latch_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // registered drive outputs
  // -----------------------------------------------------------------
  wire logic in_cut = (state_r == sss_pkg::ST_CUT) | (state_r == sss_pkg::ST_RELEASE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cut_act_r <= 1'b0;
      cs_act_r <= 1'b0;
      pulse_r <= 1'b0;
      brake_r <= 1'b0;
      ramp_r <= 1'b0;
      ready_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      cut_act_r <= in_cut;
      cs_act_r <= cs_latch_r;
      pulse_r <= (state_r == sss_pkg::ST_RUN) | (state_r == sss_pkg::ST_STOP);
      brake_r <= (state_r == sss_pkg::ST_CUT) & cfg_r.brake_configured;
      ramp_r <= (state_r == sss_pkg::ST_STOP) & ~cfg_r.external_stop_select;
      ready_r <= (state_r == sss_pkg::ST_READY);
      run_r <= (state_r == sss_pkg::ST_RUN);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pulse_enable = pulse_r;
  assign brake_close = brake_r;
  assign quick_stop_ramp = ramp_r;
  assign torque_cut_active = cut_act_r;
  assign controlled_stop_active = cs_act_r;
  assign ready_to_switch_on = ready_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cut_then_release;
    (state_r == sss_pkg::ST_CUT && tick_r && cut_exit) ##1 (state_r == sss_pkg::ST_RELEASE);
  endsequence

  chk_cut_select: assert property (tick_r && sel_cut |=> state_r == sss_pkg::ST_CUT)
    else $error("cut selection not taken");
  chk_cut_status: assert property (in_cut |=> torque_cut_active)
    else $error("cut active status missing");
  chk_brake_order: assert property (s_cut_then_release |=> !brake_close && torque_cut_active)
    else $error("brake not released before cut withdrawn");
  chk_brake_close: assert property (state_r == sss_pkg::ST_CUT && cfg_r.brake_configured
    && $stable(cfg_r) |=> brake_close)
    else $error("brake not closed under cut");
  chk_stop_entry: assert property (tick_r && stop_req && !force_cut && !delay_zero
    && (state_r == sss_pkg::ST_READY || state_r == sss_pkg::ST_RUN)
    |=> state_r == sss_pkg::ST_STOP && timer_r == $past(delay_r))
    else $error("timed stop not started with loaded delay");
  chk_zero_delay: assert property (tick_r && stop_req && delay_zero
    && state_r == sss_pkg::ST_RUN |=> state_r == sss_pkg::ST_CUT)
    else $error("zero delay did not cut at once");
  chk_timer_expiry: assert property (tick_r && state_r == sss_pkg::ST_STOP && expire
    |=> state_r == sss_pkg::ST_CUT ##1 torque_cut_active)
    else $error("expiry did not force cut");
  chk_no_abort: assert property (tick_r && state_r == sss_pkg::ST_STOP && !expire
    && !spd_low && !force_cut |=> state_r == sss_pkg::ST_STOP)
    else $error("controlled stop aborted");
  chk_stop_kept: assert property (state_r == sss_pkg::ST_CUT && cs_latch_r
    |=> controlled_stop_active)
    else $error("stop active dropped under cut");
  chk_ramp_variant: assert property (state_r == sss_pkg::ST_STOP && $stable(cfg_r)
    |=> quick_stop_ramp == !cfg_r.external_stop_select)
    else $error("ramp variant wrong");
  chk_pulse_cut: assert property (torque_cut_active |-> !pulse_enable)
    else $error("pulses enabled under cut");
  chk_restart_edge: assert property (state_r == sss_pkg::ST_RUN
    && $past(state_r) == sss_pkg::ST_READY |-> $past(run_edge))
    else $error("restart without run edge");
  chk_tick_period: assert property (tick_r |-> tick_cnt_r == '0 ##1 !tick_r)
    else $error("tick period broken");

endmodule

// >>> tb/sss_plc_model.sv
/*
  Behavioural safety controller beside the sequencer: drives the fail-safe
  pin, the speed-below-shutdown pin and the fault cause pin.
  Assumes commands from the bench, changed just after rising pclk edges.
*/
// ---------------------------------------------------------------
// safety controller pin model
// ---------------------------------------------------------------
module sss_plc_model #(
  parameter int RAMP_CYCLES = 24
) (
  input wire logic pclk,
  input wire logic fdi_sel,
  input wire logic ramp_go,
  input wire logic fault_on,
  output logic failsafe_input_n,
  output logic speed_below_shutdown,
  output logic fault_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp_cnt;

  // pins at rest: fail-safe pin released, speed high, no fault
  initial begin
    failsafe_input_n = 1'h1;
    speed_below_shutdown = 1'h0;
    fault_cause = 1'h0;
    ramp_cnt = 0;
  end

  // setpoint ramp-down reaches shutdown speed well inside the delay
  always @(posedge pclk) begin
    failsafe_input_n <= !fdi_sel; // active low pin
    fault_cause <= fault_on;
    if (!ramp_go) begin
      ramp_cnt <= 0;
    end else if (ramp_cnt < RAMP_CYCLES) begin
      ramp_cnt <= ramp_cnt + 1;
    end
    speed_below_shutdown <= ramp_go && (ramp_cnt >= RAMP_CYCLES);
  end
endmodule

// >>> tb/test_safe_stop_sequencer.sv
/*
  Self-checking bench of the safe stop sequencer: APB master tasks, pin
  model, timing monitor and the scenario sequence.
  Assumes sss_top with a shortened tick and the pin model beside it.
*/
module test_safe_stop_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 8;
  localparam int LIMIT = 6000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic fdi_sel, ramp_go, fault_on, failsafe_input_n, speed_below_shutdown, fault_cause;
  logic pulse_enable, brake_close, quick_stop_ramp, torque_cut_active;
  logic controlled_stop_active, ready_to_switch_on;
  logic cs_q, cut_q, brk_q, qsr_at_cs, cut_at_brk, cs_at_cut, brk_at_cut, ext, brk;
  int n_fail, checked, cyc, t_cs, t_cut, d;

  sss_top #(.TICK_CYCLES(TICK)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .failsafe_input_n(failsafe_input_n), .speed_below_shutdown(speed_below_shutdown),
    .fault_cause(fault_cause), .pulse_enable(pulse_enable), .brake_close(brake_close),
    .quick_stop_ramp(quick_stop_ramp), .torque_cut_active(torque_cut_active),
    .controlled_stop_active(controlled_stop_active),
    .ready_to_switch_on(ready_to_switch_on)
  );

  sss_plc_model plc (
    .pclk(pclk), .fdi_sel(fdi_sel), .ramp_go(ramp_go), .fault_on(fault_on),
    .failsafe_input_n(failsafe_input_n), .speed_below_shutdown(speed_below_shutdown),
    .fault_cause(fault_cause)
  );

  // ---------------------------------------------------------------
  // clock and edge monitor
  // ---------------------------------------------------------------
  initial pclk = 1'h0;
  always #5 pclk = ~pclk;

  // timestamps of stop entry and cut entry, brake release order, hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    cs_q <= controlled_stop_active;
    cut_q <= torque_cut_active;
    brk_q <= brake_close;
    if (controlled_stop_active && !cs_q) begin
      t_cs <= cyc;
      qsr_at_cs <= quick_stop_ramp;
    end
    if (torque_cut_active && !cut_q) begin
      t_cut <= cyc;
      cs_at_cut <= controlled_stop_active;
      brk_at_cut <= brake_close;
    end
    if (!brake_close && brk_q) cut_at_brk <= torque_cut_active;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ctrl_w(input logic cut, input logic stp, input logic run);
    logic [31:0] w;
    w = 32'h0;
    w[sss_pkg::CTRL_CUT] = cut;
    w[sss_pkg::CTRL_STOP] = stp;
    w[sss_pkg::CTRL_RUN] = run;
    return w;
  endfunction

  function automatic logic [31:0] cfg_w(input logic e, input logic b);
    logic [31:0] w;
    w = 32'h0;
    w[sss_pkg::CFG_EXT] = e;
    w[sss_pkg::CFG_BRAKE] = b;
    return w;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // no local timeout: only pready or the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge pclk);
  endtask

  // run command low then high across ticks, drive running
  task automatic restart();
    apb(1'h1, sss_pkg::OFF_CTRL, 32'h0);
    ticks(2);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
    ticks(2);
    check(pulse_enable, 32'h1);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, fdi_sel, ramp_go, fault_on} = 7'h0;
    {cs_q, cut_q, brk_q, qsr_at_cs, cut_at_brk, cs_at_cut, brk_at_cut} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {n_fail, checked, cyc, t_cs, t_cut} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    seed = 32'h96FB3691;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'h0, 8'h18, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'h1, sss_pkg::OFF_STATUS, 32'hFF);
    check(err, 32'h1);
    ticks(6);
    check(ready_to_switch_on, 32'h1);
    $display("test reset done");
    // telegram cut with brake, then release
    apb(1'h1, sss_pkg::OFF_CFG, cfg_w(1'h0, 1'h1));
    restart();
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h1, 1'h0, 1'h1));
    ticks(2);
    apb(1'h0, sss_pkg::OFF_STATUS, 32'h0);
    check(rd[0], 32'h1);
    check({brake_close, pulse_enable}, 32'h2);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
    ticks(3);
    check(cut_at_brk, 32'h1);
    check({ready_to_switch_on, pulse_enable}, 32'h2);
    $display("test telegram cut done");
    // fail-safe pin cut
    restart();
    fdi_sel <= 1'h1;
    ticks(2);
    check(torque_cut_active, 32'h1);
    fdi_sel <= 1'h0;
    ticks(3);
    check(torque_cut_active, 32'h0);
    $display("test pin cut done");
    // timed stops, both variants, deselected mid-stop
    for (int i = 0; i < 4; i++) begin
      ext = i[0];
      brk = 1'(next_rand());
      d = 3 + (next_rand() % 8);
      apb(1'h1, sss_pkg::OFF_CFG, cfg_w(ext, brk));
      apb(1'h1, sss_pkg::OFF_DELAY, 32'(d));
      restart();
      apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h1, 1'h1));
      repeat (TICK + 2) @(posedge pclk);
      check(controlled_stop_active, 32'h1);
      apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
      ticks(d + 1);
      check(32'(t_cut - t_cs), 32'(d * TICK));
      check(qsr_at_cs, {31'h0, ~ext});
      check({cs_at_cut, brk_at_cut}, {30'h0, 1'h1, brk});
      ticks(3);
      check({ready_to_switch_on, pulse_enable}, 32'h2);
    end
    $display("test timed stop done");
    // speed under shutdown ends a long stop early
    apb(1'h1, sss_pkg::OFF_CFG, cfg_w(1'h1, 1'h0));
    apb(1'h1, sss_pkg::OFF_DELAY, 32'd40);
    restart();
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h1, 1'h1));
    ramp_go <= 1'h1;
    ticks(8);
    check(torque_cut_active, 32'h1);
    check(32'(t_cut - t_cs < 40 * TICK), 32'h1);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
    ramp_go <= 1'h0;
    ticks(3);
    $display("test speed stop done");
    // zero delay acts as immediate cut
    apb(1'h1, sss_pkg::OFF_DELAY, 32'h0);
    restart();
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h1, 1'h1));
    ticks(2);
    check({torque_cut_active, quick_stop_ramp}, 32'h2);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
    ticks(3);
    $display("test zero delay done");
    // fault latched until cut select and deselect; log cleared apart
    restart();
    fault_on <= 1'h1;
    ticks(2);
    fault_on <= 1'h0;
    ticks(3);
    check(torque_cut_active, 32'h1);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h1, 1'h0, 1'h1));
    ticks(2);
    apb(1'h1, sss_pkg::OFF_CTRL, ctrl_w(1'h0, 1'h0, 1'h1));
    ticks(3);
    check(ready_to_switch_on, 32'h1);
    apb(1'h0, sss_pkg::OFF_FLOG, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, sss_pkg::OFF_FLOG, 32'h1);
    apb(1'h0, sss_pkg::OFF_FLOG, 32'h0);
    check(rd, 32'h0);
    $display("test fault done");
    // fail-safe pin configured to pick the controlled stop instead of cut
    apb(1'h1, sss_pkg::OFF_DELAY, 32'h3);
    apb(1'h1, sss_pkg::OFF_CFG, 32'h1 << sss_pkg::CFG_FDI_STOP);
    restart();
    fdi_sel <= 1'h1;
    ticks(2);
    check({controlled_stop_active, torque_cut_active}, 32'h2);
    fdi_sel <= 1'h0;
    ticks(6);
    check({ready_to_switch_on, torque_cut_active}, 32'h2);
    $display("test pin stop done");
    close_out();
  end
endmodule
